/* rtl/orbc_pkg.sv */
// constants and types for the output routing and brake control block
//
// Behaviour
// - source byte 00 gives constant one, 01 gives constant zero.
// - sources 02..08 give encoder step pulses divided by 1..64.
// - sources 09..0F give position step pulses divided by 1..64.
// - source 10 gives brake PWM, 11 gives inverted brake PWM.
// - with divider one, each single step makes exactly one pulse.
// - low byte picks the gating control bit; 0x80 means bit zero inverted.
// - automatic brake stays engaged outside the enabled power sequence.
// - config bit 2 set is automatic, cleared follows control bit 0.
// - enable: current on, delay, release brake, delay, operation enabled.
// - disable: stop motor, delay, engage brake, delay, current off.
// - in automatic mode the released brake carries PWM; frequency above 2000 Hz is refused.
// - duty is 2..100 percent; 100 holds the output on steadily.
// - routing acts only while routing enable is one.
// - routing word is 16 bits: high byte source, low byte gate bit.
// - bit 7 of the routing word inverts the gating sense.
package orbc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int CLK_HZ = 250_000_000;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int DUTY_STEP = CLK_HZ / 100;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OCW = 8'h04;
    localparam logic [7:0] A_FREQ = 8'h08;
    localparam logic [7:0] A_DUTY = 8'h0C;
    localparam logic [7:0] A_DREL = 8'h10;
    localparam logic [7:0] A_DENG = 8'h14;
    localparam logic [7:0] A_ROUTE0 = 8'h18;
    localparam logic [7:0] A_STAT = 8'h28;
    localparam int N_OUT = 4;

    localparam int CTRL_ROUTE_EN_BIT = 0;
    localparam int CTRL_AUTO_BIT = 2;
    localparam int ROUTE_INV_BIT = 7;
    localparam int OCW_OUT_LSB = 16;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] FREQ_RST = 16'h03E8;
    localparam logic [6:0] DUTY_RST = 7'h64;
    localparam logic [15:0] FREQ_MAX = 16'h07D0;
    localparam logic [6:0] DUTY_MIN = 7'h02;
    localparam logic [6:0] DUTY_MAX = 7'h64;
    localparam logic [31:0] DELAY_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // routing sources
    // ------------------------------------------------------------
    localparam logic [7:0] SRC_ONE = 8'h00;
    localparam logic [7:0] SRC_ZERO = 8'h01;
    localparam logic [7:0] SRC_ENC_LO = 8'h02;
    localparam logic [7:0] SRC_ENC_HI = 8'h08;
    localparam logic [7:0] SRC_POS_LO = 8'h09;
    localparam logic [7:0] SRC_POS_HI = 8'h0F;
    localparam logic [7:0] SRC_PWM = 8'h10;
    localparam logic [7:0] SRC_PWM_N = 8'h11;

    typedef enum logic [2:0] {
        ST_OFF, ST_PRE_REL, ST_POST_REL, ST_OPEN, ST_PRE_ENG, ST_POST_ENG
    } orbc_seq_t;

endpackage

/* rtl/orbc_pwm_if.sv */
// settings and waveform passed between the top and the brake PWM
`timescale 1ns/10ps
`default_nettype none
interface orbc_pwm_if;
    logic [15:0] freq;
    logic [6:0] duty;
    logic wave;
    modport ctrl (output freq, output duty, input wave);
    modport gen (input freq, input duty, output wave);
endinterface
`default_nettype wire

/* rtl/orbc_brake_pwm.sv */
// brake PWM generator: phase accumulator wrapping at the clock rate
`timescale 1ns/10ps
`default_nettype none
module orbc_brake_pwm (
    input wire logic clk,
    input wire logic rst,
    orbc_pwm_if.gen pwm
);
    logic [31:0] acc_reg;
    logic [31:0] acc_sum;
    logic [15:0] freq_reg;
    logic [6:0] duty_reg;
    logic [31:0] thr_reg;
    logic wave_reg;

    assign acc_sum = acc_reg + {16'h0000, freq_reg};
    assign pwm.wave = wave_reg;

    // settings are taken at a period boundary, or at once while the frequency is zero,
    // so a write never produces a runt pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= 32'h0000_0000;
            freq_reg <= orbc_pkg::FREQ_RST;
            duty_reg <= orbc_pkg::DUTY_RST;
            thr_reg <= 32'h0000_0000;
        end else if (acc_sum >= 32'(orbc_pkg::CLK_HZ)) begin
            acc_reg <= acc_sum - 32'(orbc_pkg::CLK_HZ);
            freq_reg <= pwm.freq;
            duty_reg <= pwm.duty;
            thr_reg <= 32'(pwm.duty) * 32'(orbc_pkg::DUTY_STEP);
        end else begin
            acc_reg <= acc_sum;
            if (freq_reg == 16'h0000) begin
                freq_reg <= pwm.freq;
                duty_reg <= pwm.duty;
                thr_reg <= 32'(pwm.duty) * 32'(orbc_pkg::DUTY_STEP);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wave_reg <= 1'b0;
        end else if (duty_reg == orbc_pkg::DUTY_MAX) begin
            wave_reg <= 1'b1;
        end else begin
            wave_reg <= (acc_reg < thr_reg);
        end
    end

    property p_full_duty;
        @(posedge clk) disable iff (rst)
        duty_reg == orbc_pkg::DUTY_MAX |=> wave_reg;
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("full duty did not hold output high");

endmodule
`default_nettype wire

/* rtl/orbc_top.sv */
// output routing and brake sequencing with an APB register file
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module orbc_top #(
    parameter int MS_CYCLES = orbc_pkg::MS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_step,
    input wire logic pos_step,
    input wire logic enable_req,
    output logic [3:0] dout,
    output logic brake_out,
    output logic motor_current_on,
    output logic motor_stop,
    output logic op_enabled
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pulse when a step wraps the low k bits of the step counter
    function automatic logic div_pulse(input logic [5:0] cnt,
                                       input logic step,
                                       input logic [2:0] k);
        logic [5:0] mask;
        mask = 6'(7'h01 << k) - 6'h01;
        div_pulse = step && ((cnt & mask) == mask);
    endfunction

    function automatic logic in_range(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ocw_reg;
    logic [15:0] freq_reg;
    logic [6:0] duty_reg;
    logic [31:0] drel_reg;
    logic [31:0] deng_reg;
    logic [15:0] route_reg [orbc_pkg::N_OUT];
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] rd_next;
    logic hit_next;
    logic wr_en;
    logic route_en;
    logic auto_mode;

    orbc_pkg::orbc_seq_t seq_reg;
    logic [15:0] ms_left_reg;
    logic [31:0] pre_cnt_reg;
    logic tmr_start_reg;
    logic ms_tick;
    logic brake_rel_reg;
    logic cur_on_reg;
    logic stop_reg;
    logic op_en_reg;

    logic [5:0] enc_cnt_reg;
    logic [5:0] pos_cnt_reg;
    logic [3:0] dout_reg;
    logic [3:0] dout_next;
    logic [3:0] gate_w;
    logic brake_reg;

    orbc_pwm_if pwm_bus ();

    assign wr_en = psel && penable && pready_reg && pwrite;
    assign route_en = ctrl_reg[orbc_pkg::CTRL_ROUTE_EN_BIT];
    assign auto_mode = ctrl_reg[orbc_pkg::CTRL_AUTO_BIT];
    assign pwm_bus.freq = freq_reg;
    assign pwm_bus.duty = duty_reg;

    orbc_brake_pwm u_pwm (
        .clk(clk),
        .rst(rst),
        .pwm(pwm_bus)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000;
        hit_next = 1'b1;
        case (paddr)
            orbc_pkg::A_CTRL: rd_next = ctrl_reg;
            orbc_pkg::A_OCW: rd_next = ocw_reg;
            orbc_pkg::A_FREQ: rd_next = {16'h0000, freq_reg};
            orbc_pkg::A_DUTY: rd_next = {25'h0000000, duty_reg};
            orbc_pkg::A_DREL: rd_next = drel_reg;
            orbc_pkg::A_DENG: rd_next = deng_reg;
            orbc_pkg::A_ROUTE0: rd_next = {16'h0000, route_reg[0]};
            orbc_pkg::A_ROUTE0 + 8'h04: rd_next = {16'h0000, route_reg[1]};
            orbc_pkg::A_ROUTE0 + 8'h08: rd_next = {16'h0000, route_reg[2]};
            orbc_pkg::A_ROUTE0 + 8'h0C: rd_next = {16'h0000, route_reg[3]};
            orbc_pkg::A_STAT: rd_next = {16'h0000, ms_left_reg} |
                {4'h0, brake_reg, op_en_reg, stop_reg, cur_on_reg,
                 brake_rel_reg, seq_reg, dout_reg, 16'h0000};
            default: hit_next = 1'b0;
        endcase
    end

    // answer in the first access cycle; read data is sampled in setup
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !hit_next;
            if (psel && !penable) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= orbc_pkg::CTRL_RST;
            ocw_reg <= 32'h0000_0000;
            drel_reg <= orbc_pkg::DELAY_RST;
            deng_reg <= orbc_pkg::DELAY_RST;
        end else if (wr_en) begin
            case (paddr)
                orbc_pkg::A_CTRL: ctrl_reg <= pwdata;
                orbc_pkg::A_OCW: ocw_reg <= pwdata;
                orbc_pkg::A_DREL: drel_reg <= pwdata;
                orbc_pkg::A_DENG: deng_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // out-of-range settings are dropped, the old value stays
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_reg <= orbc_pkg::FREQ_RST;
            duty_reg <= orbc_pkg::DUTY_RST;
        end else if (wr_en) begin
            if (paddr == orbc_pkg::A_FREQ &&
                pwdata <= {16'h0000, orbc_pkg::FREQ_MAX}) begin
                freq_reg <= pwdata[15:0];
            end
            if (paddr == orbc_pkg::A_DUTY &&
                pwdata >= {25'h0000000, orbc_pkg::DUTY_MIN} &&
                pwdata <= {25'h0000000, orbc_pkg::DUTY_MAX}) begin
                duty_reg <= pwdata[6:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < orbc_pkg::N_OUT; i++) begin
                route_reg[i] <= 16'h0000;
            end
        end else if (wr_en) begin
            for (int i = 0; i < orbc_pkg::N_OUT; i++) begin
                if (paddr == orbc_pkg::A_ROUTE0 + 8'(4 * i)) begin
                    route_reg[i] <= pwdata[15:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------
    assign ms_tick = (pre_cnt_reg == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst || tmr_start_reg || ms_tick) begin
            pre_cnt_reg <= 32'h0000_0000;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // power and brake sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_reg <= orbc_pkg::ST_OFF;
            ms_left_reg <= 16'h0000;
            tmr_start_reg <= 1'b0;
            brake_rel_reg <= 1'b0;
            cur_on_reg <= 1'b0;
            stop_reg <= 1'b0;
            op_en_reg <= 1'b0;
        end else begin
            tmr_start_reg <= 1'b0;
            if (ms_tick && ms_left_reg != 16'h0000) begin
                ms_left_reg <= ms_left_reg - 16'h0001;
            end
            case (seq_reg)
                orbc_pkg::ST_OFF: begin
                    if (enable_req) begin
                        cur_on_reg <= 1'b1;
                        ms_left_reg <= drel_reg[15:0];
                        tmr_start_reg <= 1'b1;
                        seq_reg <= orbc_pkg::ST_PRE_REL;
                    end
                end
                orbc_pkg::ST_PRE_REL, orbc_pkg::ST_POST_REL,
                orbc_pkg::ST_OPEN: begin
                    if (!enable_req) begin
                        stop_reg <= 1'b1;
                        op_en_reg <= 1'b0;
                        ms_left_reg <= deng_reg[15:0];
                        tmr_start_reg <= 1'b1;
                        seq_reg <= orbc_pkg::ST_PRE_ENG;
                    end else if (seq_reg == orbc_pkg::ST_PRE_REL &&
                                 ms_left_reg == 16'h0000) begin
                        brake_rel_reg <= 1'b1;
                        ms_left_reg <= drel_reg[31:16];
                        tmr_start_reg <= 1'b1;
                        seq_reg <= orbc_pkg::ST_POST_REL;
                    end else if (seq_reg == orbc_pkg::ST_POST_REL &&
                                 ms_left_reg == 16'h0000) begin
                        op_en_reg <= 1'b1;
                        seq_reg <= orbc_pkg::ST_OPEN;
                    end
                end
                orbc_pkg::ST_PRE_ENG: begin
                    if (ms_left_reg == 16'h0000) begin
                        brake_rel_reg <= 1'b0;
                        ms_left_reg <= deng_reg[31:16];
                        tmr_start_reg <= 1'b1;
                        seq_reg <= orbc_pkg::ST_POST_ENG;
                    end
                end
                orbc_pkg::ST_POST_ENG: begin
                    if (ms_left_reg == 16'h0000) begin
                        cur_on_reg <= 1'b0;
                        stop_reg <= 1'b0;
                        seq_reg <= orbc_pkg::ST_OFF;
                    end
                end
                default: seq_reg <= orbc_pkg::ST_OFF;
            endcase
        end
    end

    // brake pin: in automatic mode engaged unless the sequence released it, otherwise follows ocw_reg bit 0
    always_ff @(posedge clk) begin
        if (rst) begin
            brake_reg <= 1'b0;
        end else if (auto_mode) begin
            brake_reg <= brake_rel_reg && pwm_bus.wave;
        end else begin
            brake_reg <= ocw_reg[0];
        end
    end

    // ------------------------------------------------------------
    // output routing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            enc_cnt_reg <= 6'h00;
            pos_cnt_reg <= 6'h00;
        end else begin
            if (enc_step) enc_cnt_reg <= enc_cnt_reg + 6'h01;
            if (pos_step) pos_cnt_reg <= pos_cnt_reg + 6'h01;
        end
    end

    always_comb begin
        logic [7:0] src;
        logic sig;
        src = 8'h00;
        sig = 1'b0;
        gate_w = 4'h0;
        dout_next = 4'h0;
        for (int i = 0; i < orbc_pkg::N_OUT; i++) begin
            src = route_reg[i][15:8];
            gate_w[i] = ocw_reg[route_reg[i][4:0]] ^
                route_reg[i][orbc_pkg::ROUTE_INV_BIT];
            if (src == orbc_pkg::SRC_ONE) begin
                sig = 1'b1;
            end else if (in_range(src, orbc_pkg::SRC_ENC_LO,
                                  orbc_pkg::SRC_ENC_HI)) begin
                sig = div_pulse(enc_cnt_reg, enc_step,
                    3'(src - orbc_pkg::SRC_ENC_LO));
            end else if (in_range(src, orbc_pkg::SRC_POS_LO,
                                  orbc_pkg::SRC_POS_HI)) begin
                sig = div_pulse(pos_cnt_reg, pos_step,
                    3'(src - orbc_pkg::SRC_POS_LO));
            end else if (src == orbc_pkg::SRC_PWM) begin
                sig = pwm_bus.wave;
            end else if (src == orbc_pkg::SRC_PWM_N) begin
                sig = !pwm_bus.wave;
            end else begin
                sig = 1'b0;
            end
            if (route_en) begin
                dout_next[i] = gate_w[i] && sig;
            end else begin
                dout_next[i] = ocw_reg[orbc_pkg::OCW_OUT_LSB + i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout_reg <= 4'h0;
        end else begin
            dout_reg <= dout_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign dout = dout_reg;
    assign brake_out = brake_reg;
    assign motor_current_on = cur_on_reg;
    assign motor_stop = stop_reg;
    assign op_enabled = op_en_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_enable_start;
        seq_reg == orbc_pkg::ST_OFF && enable_req ##1
            seq_reg == orbc_pkg::ST_PRE_REL;
    endsequence

    sequence s_engage_end;
        seq_reg == orbc_pkg::ST_POST_ENG && ms_left_reg == 16'h0000 ##1
            seq_reg == orbc_pkg::ST_OFF;
    endsequence

    property p_const_one;
        @(posedge clk) disable iff (rst)
        route_en && route_reg[0][15:8] == orbc_pkg::SRC_ONE && gate_w[0]
            |=> dout_reg[0];
    endproperty
    a_const_one: assert property (p_const_one)
        else $error("constant one source not driven");

    property p_const_zero;
        @(posedge clk) disable iff (rst)
        route_en && route_reg[0][15:8] == orbc_pkg::SRC_ZERO
            |=> !dout_reg[0];
    endproperty
    a_const_zero: assert property (p_const_zero)
        else $error("constant zero source not driven");

    property p_div1;
        @(posedge clk) disable iff (rst)
        route_en && route_reg[0][15:8] == orbc_pkg::SRC_ENC_LO &&
            gate_w[0] && enc_step |=> dout_reg[0];
    endproperty
    a_div1: assert property (p_div1)
        else $error("divider one missed an encoder step");

    property p_enable_current;
        @(posedge clk) disable iff (rst)
        s_enable_start |-> cur_on_reg && !brake_rel_reg && !op_en_reg;
    endproperty
    a_enable_current: assert property (p_enable_current)
        else $error("enable did not start with current on, brake held");

    property p_op_after_release;
        @(posedge clk) disable iff (rst)
        $rose(op_en_reg) |-> brake_rel_reg && $past(brake_rel_reg)
            && cur_on_reg;
    endproperty
    a_op_after_release: assert property (p_op_after_release)
        else $error("operation enabled before brake release");

    property p_current_off_last;
        @(posedge clk) disable iff (rst)
        s_engage_end |-> !cur_on_reg && !brake_rel_reg;
    endproperty
    a_current_off_last: assert property (p_current_off_last)
        else $error("current off sequence broken");

    property p_auto_engaged;
        @(posedge clk) disable iff (rst)
        auto_mode && !brake_rel_reg |=> !brake_reg;
    endproperty
    a_auto_engaged: assert property (p_auto_engaged)
        else $error("brake released outside the enable sequence");

    property p_manual;
        @(posedge clk) disable iff (rst)
        !auto_mode |=> brake_reg == $past(ocw_reg[0]);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual brake does not follow control bit 0");

    property p_freq_reject;
        @(posedge clk) disable iff (rst)
        wr_en && paddr == orbc_pkg::A_FREQ &&
            pwdata > {16'h0000, orbc_pkg::FREQ_MAX}
            |=> $stable(freq_reg);
    endproperty
    a_freq_reject: assert property (p_freq_reject)
        else $error("frequency above limit accepted");

    property p_route_off;
        @(posedge clk) disable iff (rst)
        !route_en |=> dout_reg == $past(ocw_reg[19:16]);
    endproperty
    a_route_off: assert property (p_route_off)
        else $error("outputs not following control word");

endmodule
`default_nettype wire

/* verif/orbc_step_model.sv */
// encoder and position step source standing in for the feedback sensors
`timescale 1ns/10ps
`default_nettype none
module orbc_step_model (
    input wire logic clk,
    output logic enc_step,
    output logic pos_step
);
    initial begin
        enc_step = 1'b0;
        pos_step = 1'b0;
    end
    // one pulse per increment; gap idles a slow sensor between steps
    task automatic burst(input logic pos, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            if (pos) begin
                pos_step <= 1'b1;
            end else begin
                enc_step <= 1'b1;
            end
            @(posedge clk);
            // held high when back to back, so no double drive in one step
            if (gap > 0 || i == n - 1) begin
                enc_step <= 1'b0;
                pos_step <= 1'b0;
            end
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* verif/test_output_routing_brake_ctrl.sv */
// self-checking bench for the output routing and brake control block
`timescale 1ns/10ps
`default_nettype none
module test_output_routing_brake_ctrl;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, perr;
    logic enable_req, enc_step, pos_step;
    logic brake_out, motor_current_on, motor_stop, op_enabled;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] dout;
    int err_count = 0;
    int num_checks = 0;
    int n, c;
    orbc_top #(.MS_CYCLES(4)) dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enc_step(enc_step), .pos_step(pos_step), .enable_req(enable_req),
        .dout(dout), .brake_out(brake_out),
        .motor_current_on(motor_current_on), .motor_stop(motor_stop),
        .op_enabled(op_enabled));
    orbc_step_model model (.clk(clk), .enc_step(enc_step),
        .pos_step(pos_step));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic until_lvl(ref logic s, input logic v, output int k);
        k = 0;
        while (s !== v && k < 200) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic t_regs();
        logic [31:0] w [6] = '{32'h7D1, 32'h7D0, 1, 32'h65, 2, 32'h64};
        logic [31:0] e [6] = '{32'h3E8, 32'h7D0, 32'h64, 32'h64, 2, 32'h64};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, (i < 2) ? orbc_pkg::A_FREQ : orbc_pkg::A_DUTY, w[i]);
            apb(1'b0, (i < 2) ? orbc_pkg::A_FREQ : orbc_pkg::A_DUTY, 0);
            chk(rd, e[i]);
        end
        apb(1'b0, 8'h2C, 0);
        chk({31'h0, perr}, 1);
    endtask
    task automatic t_route();
        logic [15:0] r [9] = '{16'h0000, 16'h0000, 16'h0100, 16'h0080,
            16'h0080, 16'h0005, 16'h1000, 16'h1100, 16'h1200};
        logic [5:0] o [9] = '{1, 0, 1, 0, 1, 6'h20, 1, 1, 1};
        logic e [9] = '{1, 0, 0, 1, 0, 1, 1, 0, 0};
        apb(1'b1, orbc_pkg::A_CTRL, 1);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, orbc_pkg::A_OCW, {26'h0, o[i]});
            apb(1'b1, orbc_pkg::A_ROUTE0, {16'h0, r[i]});
            chk(dout, {{3{o[i][0]}}, e[i]});
        end
        apb(1'b1, orbc_pkg::A_CTRL, 0);
        apb(1'b1, orbc_pkg::A_OCW, 32'h000A_0000);
        chk(dout, 4'hA);
    endtask
    task automatic t_div();
        apb(1'b1, orbc_pkg::A_CTRL, 1);
        apb(1'b1, orbc_pkg::A_OCW, 1);
        for (int s = 2; s < 16; s++) begin
            apb(1'b1, orbc_pkg::A_ROUTE0, s << 8);
            n = 0;
            fork
                model.burst(s > 8, 64, s % 2);
                repeat (140) begin
                    @(posedge clk);
                    if (dout[0] === 1'b1) begin
                        n++;
                    end
                end
            join
            chk(n, 64 >> ((s - 2) % 7));
        end
    endtask
    task automatic t_brake();
        apb(1'b1, orbc_pkg::A_OCW, 1);
        chk(brake_out, 1);
        apb(1'b1, orbc_pkg::A_OCW, 0);
        chk(brake_out, 0);
        apb(1'b1, orbc_pkg::A_CTRL, 4);
        apb(1'b1, orbc_pkg::A_DREL, 32'h0003_0002);
        apb(1'b1, orbc_pkg::A_DENG, 32'h0001_0002);
        enable_req <= 1'b1;
        until_lvl(motor_current_on, 1'b1, c);
        chk(c <= 2 && brake_out === 1'b0, 1);
        until_lvl(brake_out, 1'b1, c);
        chk(c >= 4 && c <= 11 && op_enabled === 1'b0, 1);
        until_lvl(op_enabled, 1'b1, c);
        chk(c >= 7 && c <= 15, 1);
        enable_req <= 1'b0;
        until_lvl(motor_stop, 1'b1, c);
        chk(c <= 2, 1);
        until_lvl(brake_out, 1'b0, c);
        chk(c >= 4 && c <= 11 && op_enabled === 1'b0, 1);
        until_lvl(motor_current_on, 1'b0, c);
        chk(c >= 2 && c <= 7 && brake_out === 1'b0, 1);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, enable_req} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_route();
        t_div();
        t_brake();
        conclude();
    end
endmodule
`default_nettype wire
